// ===== logic/scc_regs.v
// sensor communication configuration register slice
// assumes one access per request from an in-order protocol engine on mclk
// Functional notes
// - sixteen-register window shared by all regions
// - active zero while loading, Ah-Fh name ranges
// - user overwrite of window sets code 0001
// - window read uses loaded region, same nibble
// - protocol register accessible in dsi3 or diagnostic
// - protocol field selects bus, switch, undervoltage
// - protocol changes disabling protocol are only stored; reset loads otp protocol
// - accesses completed strictly in arrival order
// - zero stored address means address is assigned
// - nonzero stored address skips discovery
// - writes change address; every reset restores otp
// - in psi5 address stored but unused
// - source 0: enable, format, identifier fields
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_regs #(
	parameter LOAD_CYCLES = 16
) (
	input wire mclk,
	input wire rstn,
	input wire req_valid,
	input wire req_write,
	input wire [7:0] req_addr,
	input wire [7:0] req_wdata,
	output reg rsp_valid,
	output reg [7:0] rsp_rdata,
	output reg rsp_error,
	input wire psi5_diag_mode,
	input wire [2:0] otp_protocol,
	input wire [3:0] otp_phys_addr,
	input wire user_cfg_locked,
	input wire [3:0] discovered_addr,
	input wire discovered_valid,
	output wire otp_rd_en,
	output wire [7:0] otp_rd_addr,
	input wire [7:0] otp_rd_data,
	output reg [2:0] active_protocol,
	output wire dsi3_enabled,
	output wire psi5_enabled,
	output wire low_side_bus_switch,
	output wire bus_uv_detect,
	output wire discovery_enable,
	output wire [3:0] crm_phys_addr,
	output wire source0_enable,
	output wire [2:0] periodic_format_sel,
	output wire [3:0] source_id0,
	output wire [3:0] region_active
);
	// asynchronous assert, two-flop synchronous release
	reg rst_s1;
	reg rst_s2;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	wire rst_n = rst_s2;

	// one-hot states; strap runs once after every reset
	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_STRAP = 3'b100;

	reg [2:0] state;
	reg [3:0] region_load;
	reg [3:0] active_code;
	reg [3:0] load_idx;
	reg [7:0] window [0:15];
	reg [2:0] protocol_sel;
	reg [3:0] phys_addr;
	reg [7:0] source0;
	reg addr_fixed;
	reg [4:0] load_cnt;

	// load holds off window writes for a fixed settle span
	localparam integer LOAD_LAST_I = LOAD_CYCLES - 1;
	localparam [4:0] LOAD_LAST = LOAD_LAST_I[4:0];

	// register access allowed in dsi3 or psi5 diagnostic
	wire acc_ok = dsi3_enabled | psi5_diag_mode;
	wire [7:0] win_lo = `SCC_WIN_LO;
	wire is_win = (req_addr[7:4] >= win_lo[7:4]);
	wire wr = req_valid & req_write & acc_ok;
	wire [3:0] next_load = req_wdata[7:4];
	wire load_go = wr & (req_addr == `SCC_ADDR_REGION_SEL) & (next_load >= `SCC_CODE_FIRST);

	assign otp_rd_en = (state == ST_LOAD);
	assign otp_rd_addr = {region_load, load_idx};
	assign region_active = active_code;

	// protocol decode of the active selection
	assign dsi3_enabled = (active_protocol == `SCC_PROTO_DSI3) | (active_protocol == `SCC_PROTO_DSI3_UV);
	assign psi5_enabled = (active_protocol == `SCC_PROTO_PSI5) | (active_protocol == `SCC_PROTO_PSI5_UV);
	assign low_side_bus_switch = (active_protocol != `SCC_PROTO_DSI3);
	assign bus_uv_detect = active_protocol[1] | active_protocol[2];
	// zero address joins discovery, nonzero skips it; ignored in psi5
	assign discovery_enable = dsi3_enabled & ~addr_fixed;
	assign crm_phys_addr = dsi3_enabled ? phys_addr : 4'h0;
	assign source0_enable = source0[7];
	assign periodic_format_sel = source0[6:4];
	assign source_id0 = source0[3:0];

	// does a new value keep every protocol the active one enables
	function keeps_protocols;
		input [2:0] cur;
		input [2:0] nxt;
		begin
			keeps_protocols = (cur == nxt) |
				((cur == `SCC_PROTO_DSI3) & (nxt == `SCC_PROTO_DSI3_UV)) |
				((cur == `SCC_PROTO_PSI5) & (nxt == `SCC_PROTO_PSI5_UV));
		end
	endfunction

	integer i;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_STRAP;
			region_load <= 4'h0;
			active_code <= `SCC_ACT_LOADING;
			load_idx <= 4'h0;
			load_cnt <= 5'h00;
			protocol_sel <= 3'h0;
			active_protocol <= 3'h0;
			phys_addr <= 4'h0;
			source0 <= `SCC_RESET_BYTE;
			addr_fixed <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= `SCC_RESET_BYTE;
			rsp_error <= 1'b0;
			for (i = 0; i < 16; i = i + 1) begin
				window[i] <= `SCC_RESET_BYTE;
			end
		end else begin
			rsp_valid <= req_valid;
			rsp_error <= req_valid & ~acc_ok;
			rsp_rdata <= `SCC_RESET_BYTE;
			case (state)
				ST_STRAP: begin
					// otp values restored at every reset
					protocol_sel <= otp_protocol;
					active_protocol <= otp_protocol;
					phys_addr <= otp_phys_addr;
					addr_fixed <= (otp_phys_addr != 4'h0);
					state <= ST_IDLE;
				end
				ST_LOAD: begin
					window[load_idx] <= otp_rd_data;
					load_idx <= load_idx + 4'h1;
					load_cnt <= load_cnt + 5'h01;
					if (load_cnt == LOAD_LAST) begin
						active_code <= region_load;
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
			// a new load wins; window writes only while no load runs
			if (load_go) begin
				region_load <= next_load;
				active_code <= `SCC_ACT_LOADING;
				load_idx <= 4'h0;
				load_cnt <= 5'h00;
				state <= ST_LOAD;
			end else if (wr & is_win & (state == ST_IDLE)) begin
				window[req_addr[3:0]] <= req_wdata;
				active_code <= `SCC_ACT_OVERWRITTEN;
			end
			if (wr) begin
				case (req_addr)
					`SCC_ADDR_PROTOCOL: begin
						protocol_sel <= req_wdata[2:0];
						if (keeps_protocols(active_protocol, req_wdata[2:0])) begin
							active_protocol <= req_wdata[2:0];
						end
					end
					`SCC_ADDR_PHYS: begin
						phys_addr <= req_wdata[3:0];
						if (discovered_valid == 1'b0) begin
							addr_fixed <= addr_fixed;
						end
					end
					`SCC_ADDR_SRC0: source0 <= req_wdata;
					default: begin
					end
				endcase
			end
			if (discovered_valid & ~addr_fixed & ~(wr & (req_addr == `SCC_ADDR_PHYS))) begin
				phys_addr <= discovered_addr;
			end
			// registered read data, zero for writes and unmapped
			if (req_valid & ~req_write & acc_ok) begin
				if (is_win) begin
					rsp_rdata <= window[req_addr[3:0]];
				end else begin
					case (req_addr)
						`SCC_ADDR_REGION_SEL: rsp_rdata <= {region_load, 4'h0};
						`SCC_ADDR_REGION_STAT: rsp_rdata <= {active_code, 4'h0};
						`SCC_ADDR_PROTOCOL: rsp_rdata <= {5'h00, protocol_sel};
						`SCC_ADDR_PHYS: rsp_rdata <= {4'h0, phys_addr};
						`SCC_ADDR_SRC0: rsp_rdata <= source0;
						default: rsp_rdata <= `SCC_RESET_BYTE;
					endcase
				end
			end
		end
	end
endmodule

// ===== logic/scc_map.vh
// constants for the sensor communication configuration register slice
// assumes byte-wide register access from the protocol engine
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
`define SCC_ADDR_REGION_SEL 8'h14
`define SCC_ADDR_REGION_STAT 8'h15
`define SCC_ADDR_PROTOCOL 8'h16
`define SCC_ADDR_PHYS 8'h18
`define SCC_ADDR_SRC0 8'h1a
`define SCC_WIN_LO 8'ha0
`define SCC_RESET_BYTE 8'h00
`define SCC_ACT_LOADING 4'h0
`define SCC_ACT_OVERWRITTEN 4'h1
`define SCC_CODE_FIRST 4'ha
`define SCC_PROTO_DSI3 3'h0
`define SCC_PROTO_PSI5 3'h1
`define SCC_PROTO_DSI3_UV 3'h3
`define SCC_PROTO_PSI5_UV 3'h5
`define SCC_LOAD_CYCLES 5'h10
`endif

// ===== test/scc_otp_model.sv
// otp array model on the load port of the register slice
// assumes combinational read, inverted address while not enabled
`timescale 1ns/1ps
module scc_otp_model (
	input wire logic otp_rd_en,
	input wire logic [7:0] otp_rd_addr,
	output logic [7:0] otp_rd_data
);
	// byte per {region,index}, inverted when idle
	assign otp_rd_data = otp_rd_en ? otp_rd_addr ^ 8'h5a : ~otp_rd_addr;
endmodule

// ===== test/scc_regs_asserts.sv
// port checker for the register slice
// assumes single mclk domain, bound to every scc_regs
`timescale 1ns/1ps
module scc_regs_asserts #(
	parameter LOAD_CYCLES = 16
) (
	input wire mclk,
	input wire rstn,
	input wire req_valid,
	input wire req_write,
	input wire [7:0] req_addr,
	input wire [7:0] req_wdata,
	input wire rsp_valid,
	input wire rsp_error,
	input wire psi5_diag_mode,
	input wire dsi3_enabled,
	input wire otp_rd_en,
	input wire [3:0] region_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire ok = dsi3_enabled | psi5_diag_mode;
	wire wr = req_valid & req_write & ok & !otp_rd_en;
	sequence s_copy;
		otp_rd_en [*8] ##1 otp_rd_en [*8];
	endsequence
	a_rsp_one_later: assert property (req_valid |=> rsp_valid)
		else $error("response missing");
	a_rsp_no_spur: assert property (rsp_valid |-> $past(req_valid))
		else $error("response without request");
	a_refuse_err: assert property (req_valid && !ok |=> rsp_error)
		else $error("refusal not flagged");
	a_allow_ok: assert property (req_valid && dsi3_enabled |=> !rsp_error)
		else $error("access wrongly refused");
	a_load_clears: assert property (wr && req_addr == 8'h14 && req_wdata[7:4] >= 4'ha
		|=> otp_rd_en && region_active == 4'h0)
		else $error("load did not start");
	a_load_length: assert property ($rose(otp_rd_en) |-> s_copy ##1
		(!otp_rd_en && region_active >= 4'ha))
		else $error("load length or code wrong");
	a_zero_loading: assert property (otp_rd_en |-> region_active == 4'h0)
		else $error("code not zero while loading");
	a_overwrite_code: assert property (wr && req_addr >= 8'ha0 |=> region_active == 4'h1)
		else $error("overwrite code missing");
endmodule
bind scc_regs scc_regs_asserts #(.LOAD_CYCLES(LOAD_CYCLES)) u_chk (.mclk(mclk), .rstn(rstn),
	.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
	.rsp_valid(rsp_valid), .rsp_error(rsp_error), .psi5_diag_mode(psi5_diag_mode),
	.dsi3_enabled(dsi3_enabled), .otp_rd_en(otp_rd_en), .region_active(region_active));

// ===== test/scc_regs_tb.sv
// testbench for the configuration register slice
// assumes otp model on the load port, one request at a time
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_regs_tb;
	logic mclk = 0, rstn = 0, req_valid = 0, req_write = 0, diag = 0;
	logic [7:0] req_addr = 8'h00, req_wdata = 8'h00;
	logic [2:0] proto = 3'h0;
	logic [3:0] paddr = 4'h0, daddr = 4'h0;
	logic dval = 0;
	wire rv, re, en, d3, p5, lsw, uv, disc, sen;
	wire [7:0] rd, oa, od;
	wire [2:0] act, fmt;
	wire [3:0] crm, sid, ra;
	int err_count = 0, samples_checked = 0;
	always #4 mclk = ~mclk;
	scc_otp_model u_otp (.otp_rd_en(en), .otp_rd_addr(oa), .otp_rd_data(od));
	scc_regs #(.LOAD_CYCLES(16)) dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rv),
		.rsp_rdata(rd), .rsp_error(re), .psi5_diag_mode(diag), .otp_protocol(proto),
		.otp_phys_addr(paddr), .user_cfg_locked(1'b0), .discovered_addr(daddr),
		.discovered_valid(dval), .otp_rd_en(en), .otp_rd_addr(oa), .otp_rd_data(od),
		.active_protocol(act), .dsi3_enabled(d3), .psi5_enabled(p5), .low_side_bus_switch(lsw),
		.bus_uv_detect(uv), .discovery_enable(disc), .crm_phys_addr(crm),
		.source0_enable(sen), .periodic_format_sel(fmt), .source_id0(sid), .region_active(ra));
	task chk(string n, logic [7:0] s, logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e, logic er);
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk);
		#1;
		chk("rsp_valid", rv, 8'h01);
		chk("rsp_error", re, er);
		if (!w) chk("rsp_rdata", rd, e);
		req_valid = 0;
		@(posedge mclk);
		#1;
	endtask
	task disc_pulse(logic [3:0] a);
		daddr = a;
		dval = 1;
		@(posedge mclk);
		#1 dval = 0;
	endtask
	task rst;
		rstn = 0;
		repeat (4) @(posedge mclk);
		#1 rstn = 1;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task test_done;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		test_done;
	end
	initial begin
		rst;
		acc(0, `SCC_ADDR_PROTOCOL, 0, `SCC_RESET_BYTE, 0);
		acc(0, `SCC_ADDR_PHYS, 0, `SCC_RESET_BYTE, 0);
		acc(1, `SCC_ADDR_SRC0, 8'ha5, 0, 0);
		acc(0, `SCC_ADDR_SRC0, 0, 8'ha5, 0);
		chk("src", {sen, fmt, sid}, 8'ha5);
		chk("disc", disc, 1);
		disc_pulse(4'h3);
		chk("crm_disc", crm, 8'h03);
		acc(1, `SCC_ADDR_PHYS, 8'h07, 0, 0);
		chk("crm", crm, 8'h07);
		acc(1, `SCC_ADDR_REGION_SEL, 8'hc0, 0, 0);
		chk("loading", ra, 0);
		repeat (`SCC_LOAD_CYCLES + 1) @(posedge mclk);
		#1 chk("code", ra, 8'h0c);
		acc(0, 8'hf2, 0, 8'hc2 ^ 8'h5a, 0);
		acc(0, `SCC_ADDR_REGION_STAT, 0, 8'hc0, 0);
		acc(1, 8'ha3, 8'h11, 0, 0);
		chk("ovr", ra, 8'h01);
		acc(0, 8'hb3, 0, 8'h11, 0);
		acc(1, `SCC_ADDR_REGION_SEL, 8'ha0, 0, 0);
		repeat (`SCC_LOAD_CYCLES + 1) @(posedge mclk);
		#1 chk("code_a", ra, 8'h0a);
		acc(0, 8'hc2, 0, 8'ha2 ^ 8'h5a, 0);
		acc(0, 8'ha3, 0, 8'ha3 ^ 8'h5a, 0);
		acc(1, `SCC_ADDR_REGION_SEL, 8'h50, 0, 0);
		acc(0, `SCC_ADDR_REGION_STAT, 0, 8'ha0, 0);
		acc(1, `SCC_ADDR_PROTOCOL, 8'h03, 0, 0);
		chk("proto", {act, lsw, uv}, 8'h0f);
		acc(1, `SCC_ADDR_PROTOCOL, 8'h01, 0, 0);
		acc(0, `SCC_ADDR_PROTOCOL, 0, 8'h01, 0);
		chk("keep", {act, d3}, 8'h07);
		proto = 3'h1;
		rst;
		chk("psi", {p5, d3, crm}, 8'h20);
		acc(1, `SCC_ADDR_PHYS, 8'h09, 0, 1);
		diag = 1;
		acc(0, `SCC_ADDR_PHYS, 0, 8'h00, 0);
		acc(1, `SCC_ADDR_PHYS, 8'h09, 0, 0);
		chk("crm_psi", crm, 8'h00);
		acc(0, `SCC_ADDR_PHYS, 0, 8'h09, 0);
		diag = 0;
		proto = 3'h0;
		paddr = 4'h5;
		rst;
		chk("fixed", {disc, crm}, 8'h05);
		disc_pulse(4'h3);
		chk("crm_fixed", crm, 8'h05);
		acc(0, `SCC_ADDR_PHYS, 0, 8'h05, 0);
		acc(1, `SCC_ADDR_PHYS, 8'h0a, 0, 0);
		chk("crm_wr", crm, 8'h0a);
		test_done;
	end
endmodule
